/* File: rtl/mmu_access_pkg.sv */
// Constants, types and register map of the memory and register access gate.
// Assumes a 125 MHz APB clock and a CPU that issues virtual addresses only.
package mmu_access_pkg;
	localparam int VA_W = 16;
	localparam int PA_W = 17;
	localparam int SEG_N = 64;
	localparam int SEG_IW = 6;
	typedef enum logic [4:0] {
		MODE_BOOT = 5'b0_0001,
		MODE_TEST = 5'b0_0010,
		MODE_COS = 5'b0_0100,
		MODE_SYS = 5'b0_1000,
		MODE_USER = 5'b1_0000
	} mode_type;
	localparam logic [1:0] IB_BOOT = 2'h1;
	localparam logic [1:0] IB_TEST = 2'h2;
	localparam int PSW_SYS_BIT = 7;
	localparam int PSW_COS_BIT = 6;
	// Physical map: ROM, then EEPROM, then RAM
	localparam logic [PA_W-1:0] EE_BASE = 17'h0_8000;
	localparam logic [PA_W-1:0] RAM_BASE = 17'h1_0000;
	localparam logic [PA_W-1:0] TEST_ROM_END = 17'h0_1000;
	localparam logic [PA_W-1:0] COS_EE_END = 17'h0_8800;
	localparam logic [PA_W-1:0] MFR_EE_END = 17'h0_8080;
	localparam logic [PA_W-1:0] COS_RAM_END = 17'h1_0200;
	// APB byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_PSW = 8'h04;
	localparam logic [7:0] A_SEG_PTR = 8'h08;
	localparam logic [7:0] A_FW_LO = 8'h0C;
	localparam logic [7:0] A_FW_HI = 8'h10;
	localparam logic [7:0] A_XB_LO = 8'h14;
	localparam logic [7:0] A_XB_HI = 8'h18;
	localparam logic [7:0] A_XS_LO = 8'h1C;
	localparam logic [7:0] A_XS_HI = 8'h20;
	localparam logic [7:0] A_SEG_IDX = 8'h24;
	localparam logic [7:0] A_SEG_BND = 8'h28;
	localparam logic [7:0] A_SEG_ATR = 8'h2C;
	localparam logic [7:0] A_STATUS = 8'h30;
	localparam int CTRL_SUPPRESS_BIT = 2;
	localparam int CTRL_NOCOS_BIT = 3;
	localparam int ATR_R = 17;
	localparam int ATR_W = 18;
	localparam int ATR_X = 19;
	localparam int ATR_HR = 20;
	localparam int ATR_HW = 21;
	// Register groups seen on the CPU register port, by address bits [7:5]
	typedef enum logic [2:0] {
		G_CPU = 3'h0, G_MMU = 3'h1, G_SYS = 3'h2, G_FW = 3'h3,
		G_COS = 3'h4, G_TEST = 3'h5, G_HW = 3'h6, G_HW2 = 3'h7
	} sfr_group_type;
	typedef enum logic [1:0] {ACC_READ = 2'h0, ACC_WRITE = 2'h1, ACC_EXEC = 2'h2} acc_type;
endpackage

/* File: rtl/segment_table.sv */
// Segment table with two lookups: data/fetch address and executing PC.
// Assumes entries are loaded one at a time by the access gate.
`timescale 1ns/1ps
module segment_table
	import mmu_access_pkg::*;
#(
	parameter int N = SEG_N
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Entry load
	input wire logic wr_en,
	input wire logic [SEG_IW-1:0] wr_idx,
	input wire logic [VA_W-1:0] wr_first,
	input wire logic [VA_W-1:0] wr_last,
	input wire logic [PA_W-1:0] wr_offset,
	input wire logic [4:0] wr_rights,
	// Lookups
	input wire logic [VA_W-1:0] va,
	output logic va_hit,
	output logic [4:0] va_rights,
	output logic [PA_W-1:0] va_offset,
	input wire logic [VA_W-1:0] pc,
	output logic [4:0] pc_rights
);
	logic [VA_W-1:0] first_q [N];
	logic [VA_W-1:0] last_q [N];
	logic [PA_W-1:0] off_q [N];
	logic [4:0] rights_q [N];
	logic [N-1:0] va_m;
	logic [N-1:0] pc_m;
	genvar g;
	for (g = 0; g < N; g++)
	begin : g_ent
		// An entry with no memory right never matches
		assign va_m[g] = (|rights_q[g][2:0]) && va >= first_q[g] && va <= last_q[g];
		assign pc_m[g] = (|rights_q[g][2:0]) && pc >= first_q[g] && pc <= last_q[g];
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				first_q[g] <= '0;
				last_q[g] <= '0;
				off_q[g] <= '0;
				rights_q[g] <= '0;
			end
			else if (wr_en && wr_idx == SEG_IW'(g))
			begin
				first_q[g] <= wr_first;
				last_q[g] <= wr_last;
				off_q[g] <= wr_offset;
				rights_q[g] <= wr_rights;
			end
		end
	end
	// Lowest matching index wins
	always_comb
	begin
		va_hit = 1'b0;
		va_rights = '0;
		va_offset = '0;
		pc_rights = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (va_m[i])
			begin
				va_hit = 1'b1;
				va_rights = rights_q[i];
				va_offset = off_q[i];
			end
			if (pc_m[i])
				pc_rights = rights_q[i];
		end
	end
endmodule

/* File: rtl/sfr_gate.sv */
// Grant decision for one register access on the CPU register port.
// Assumes mode, segment rights and firewall masks are stable in the cycle.
`timescale 1ns/1ps
module sfr_gate
	import mmu_access_pkg::*;
(
	// Access
	input wire logic [7:0] addr,
	input wire logic we,
	input wire mode_type mode,
	// Rights sources
	input wire logic [1:0] seg_hw_rights,
	input wire logic [7:0] fw_read_mask,
	input wire logic [7:0] fw_write_mask,
	// Decision
	output logic grant
);
	sfr_group_type grp;
	logic fw_ok;
	logic seg_ok;
	assign grp = sfr_group_type'(addr[7:5]);
	assign fw_ok = we ? fw_write_mask[addr[2:0]] : fw_read_mask[addr[2:0]];
	assign seg_ok = we ? seg_hw_rights[1] : seg_hw_rights[0];
	always_comb
	begin
		grant = 1'b0;
		if (grp == G_CPU)
			grant = 1'b1;
		else
		begin
			unique case (mode)
				// Segmentation configuration stays closed outside System mode
				MODE_BOOT, MODE_TEST: grant = grp != G_MMU;
				MODE_SYS: grant = grp inside {G_MMU, G_SYS, G_FW, G_HW, G_HW2};
				MODE_COS: grant = (grp == G_FW && !we) || grp == G_COS
					|| (grp inside {G_HW, G_HW2} && fw_ok);
				MODE_USER: grant = grp inside {G_HW, G_HW2} && seg_ok;
				default: grant = 1'b0;
			endcase
		end
	end
endmodule

/* File: rtl/mmu_sfr_access_control.sv */
// Top of the memory and register access gate: APB configuration slave,
// mode tracking, address translation and register grant.
// Assumes the register file answers reads combinationally in the request cycle.
`timescale 1ns/1ps
module mmu_sfr_access_control
	import mmu_access_pkg::*;
(
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// CPU memory access
	input wire logic cpu_req,
	input wire acc_type cpu_kind,
	input wire logic [VA_W-1:0] cpu_vaddr,
	input wire logic [VA_W-1:0] cpu_pc,
	input wire logic vector_call_instr,
	output logic mem_req,
	output logic mem_we,
	output logic [PA_W-1:0] mem_paddr,
	output logic mem_fault,
	// CPU register access
	input wire logic sfr_req,
	input wire logic sfr_we,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_file_rdata,
	output logic sfr_ack,
	output logic sfr_denied,
	output logic sfr_file_we,
	output logic [7:0] sfr_rdata,
	// Mode
	output mode_type cpu_mode
);
	logic [3:0] ctrl_q, ctrl_d;
	logic [7:0] program_status_high_reg_q, psw_d;
	logic [PA_W-1:0] seg_ptr_q, seg_ptr_d;
	logic [7:0] firewall_ctrl_low_q, fwl_d, firewall_ctrl_high_q, fwh_d;
	logic [7:0] exchange_window_base_low_q, xbl_d, exchange_window_base_high_q, xbh_d;
	logic [7:0] exchange_window_size_low_q, xsl_d, exchange_window_size_high_q, xsh_d;
	logic [SEG_IW-1:0] seg_idx_q, seg_idx_d;
	logic [31:0] seg_bnd_q, seg_bnd_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic mem_req_q, mem_req_d, mem_we_q, mem_we_d, mem_fault_q, mem_fault_d;
	logic [PA_W-1:0] mem_paddr_q, mem_paddr_d;
	logic sfr_ack_q, sfr_ack_d, sfr_den_q, sfr_den_d, sfr_we_q, sfr_we_d;
	logic [7:0] sfr_rd_q, sfr_rd_d;
	mode_type mode_q, mode_d;
	logic wr_acc, mapped, seg_wr, sys_ok, sfr_grant, va_hit, ok;
	logic [4:0] va_rights, pc_rights;
	logic [PA_W-1:0] va_offset, pa, xbase, xend;

	// Mode from internal bits and status bits
	always_comb
	begin
		if (ctrl_q[1:0] == IB_BOOT)
			mode_d = MODE_BOOT;
		else if (ctrl_q[1:0] == IB_TEST)
			mode_d = MODE_TEST;
		else if (program_status_high_reg_q[PSW_COS_BIT] && !ctrl_q[CTRL_SUPPRESS_BIT])
			mode_d = MODE_COS;
		else if (program_status_high_reg_q[PSW_SYS_BIT])
			mode_d = MODE_SYS;
		else
			mode_d = MODE_USER;
	end

	// APB slave, zero wait states: data prepared in setup, pready in access
	assign wr_acc = psel && penable && pready_q && pwrite;
	assign sys_ok = mode_q == MODE_SYS;
	assign seg_wr = wr_acc && paddr == A_SEG_ATR && sys_ok;
	always_comb
	begin
		mapped = paddr <= A_STATUS && paddr[1:0] == 2'h0;
		pready_d = psel && !penable;
		pslverr_d = psel && !penable && !mapped;
		prdata_d = '0;
		if (psel && !penable && !pwrite)
		begin
			unique case (paddr)
				A_CTRL: prdata_d = {28'h000_0000, ctrl_q};
				A_PSW: prdata_d = {24'h00_0000, program_status_high_reg_q};
				A_SEG_PTR: prdata_d = {15'h0000, seg_ptr_q};
				A_FW_LO: prdata_d = {24'h00_0000, firewall_ctrl_low_q};
				A_FW_HI: prdata_d = {24'h00_0000, firewall_ctrl_high_q};
				A_XB_LO: prdata_d = {24'h00_0000, exchange_window_base_low_q};
				A_XB_HI: prdata_d = {24'h00_0000, exchange_window_base_high_q};
				A_XS_LO: prdata_d = {24'h00_0000, exchange_window_size_low_q};
				A_XS_HI: prdata_d = {24'h00_0000, exchange_window_size_high_q};
				A_SEG_IDX: prdata_d = {26'h000_0000, seg_idx_q};
				A_SEG_BND: prdata_d = seg_bnd_q;
				A_STATUS: prdata_d = {25'h000_0000, mem_fault_q, sfr_den_q, mode_q};
				default: prdata_d = '0;
			endcase
		end
	end

	// Configuration registers; firewall and segmentation are System-only
	always_comb
	begin
		ctrl_d = ctrl_q;
		psw_d = program_status_high_reg_q;
		seg_ptr_d = seg_ptr_q;
		fwl_d = firewall_ctrl_low_q;
		fwh_d = firewall_ctrl_high_q;
		xbl_d = exchange_window_base_low_q;
		xbh_d = exchange_window_base_high_q;
		xsl_d = exchange_window_size_low_q;
		xsh_d = exchange_window_size_high_q;
		seg_idx_d = seg_idx_q;
		seg_bnd_d = seg_bnd_q;
		if (wr_acc)
		begin
			unique case (paddr)
				A_CTRL: ctrl_d = pwdata[3:0];
				A_PSW: psw_d = pwdata[7:0];
				A_SEG_PTR: if (sys_ok) seg_ptr_d = pwdata[PA_W-1:0];
				A_FW_LO: if (sys_ok) fwl_d = pwdata[7:0];
				A_FW_HI: if (sys_ok) fwh_d = pwdata[7:0];
				A_XB_LO: if (sys_ok) xbl_d = pwdata[7:0];
				A_XB_HI: if (sys_ok) xbh_d = pwdata[7:0];
				A_XS_LO: if (sys_ok) xsl_d = pwdata[7:0];
				A_XS_HI: if (sys_ok) xsh_d = pwdata[7:0];
				A_SEG_IDX: if (sys_ok) seg_idx_d = pwdata[SEG_IW-1:0];
				A_SEG_BND: if (sys_ok) seg_bnd_d = pwdata;
				default: ;
			endcase
		end
		// Vector call enters OS mode only when that mode exists
		if (vector_call_instr && !ctrl_q[CTRL_SUPPRESS_BIT])
			psw_d[PSW_COS_BIT] = 1'b1;
	end

	segment_table u_seg
	(
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(seg_wr),
		.wr_idx(seg_idx_q),
		.wr_first(seg_bnd_q[VA_W-1:0]),
		.wr_last(seg_bnd_q[31:VA_W]),
		.wr_offset(pwdata[PA_W-1:0]),
		.wr_rights(pwdata[ATR_HW:ATR_R]),
		.va(cpu_vaddr),
		.va_hit(va_hit),
		.va_rights(va_rights),
		.va_offset(va_offset),
		.pc(cpu_pc),
		.pc_rights(pc_rights)
	);

	// Translation and memory permission, decided before the access leaves
	assign xbase = RAM_BASE + PA_W'({exchange_window_base_high_q, exchange_window_base_low_q});
	assign xend = xbase + PA_W'({exchange_window_size_high_q, exchange_window_size_low_q});
	always_comb
	begin
		ok = 1'b0;
		pa = PA_W'(cpu_vaddr);
		unique case (mode_q)
			MODE_USER:
			begin
				pa = PA_W'(cpu_vaddr) + va_offset;
				ok = va_hit && va_rights[ATR_R - ATR_R + 32'(cpu_kind)];
			end
			MODE_BOOT, MODE_TEST: ok = 1'b1;
			MODE_COS: ok = pa < TEST_ROM_END || (pa >= EE_BASE && pa < COS_EE_END)
				|| (pa >= RAM_BASE && pa < COS_RAM_END) || (pa >= xbase && pa < xend);
			MODE_SYS: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		// Application partitions only, for System and User
		if (mode_q inside {MODE_SYS, MODE_USER})
		begin
			if (pa < TEST_ROM_END)
				ok = 1'b0;
			else if (pa >= EE_BASE && pa < RAM_BASE)
				ok = ok && pa >= (ctrl_q[CTRL_NOCOS_BIT] ? MFR_EE_END : COS_EE_END);
			else if (pa >= RAM_BASE && pa < COS_RAM_END)
				ok = ok && ctrl_q[CTRL_NOCOS_BIT];
		end
		if (cpu_kind == ACC_WRITE && pa < EE_BASE)
			ok = 1'b0;
		if (cpu_kind == ACC_EXEC && pa >= RAM_BASE)
			ok = 1'b0;
		mem_req_d = cpu_req && ok;
		mem_we_d = cpu_req && ok && cpu_kind == ACC_WRITE;
		mem_paddr_d = (cpu_req && ok) ? pa : mem_paddr_q;
		mem_fault_d = cpu_req && !ok;
	end

	sfr_gate u_gate
	(
		.addr(sfr_addr),
		.we(sfr_we),
		.mode(mode_q),
		.seg_hw_rights(pc_rights[ATR_HW-ATR_R:ATR_HR-ATR_R]),
		.fw_read_mask(firewall_ctrl_low_q),
		.fw_write_mask(firewall_ctrl_high_q),
		.grant(sfr_grant)
	);

	always_comb
	begin
		sfr_ack_d = sfr_req;
		sfr_den_d = sfr_req && !sfr_grant;
		sfr_we_d = sfr_req && sfr_we && sfr_grant;
		sfr_rd_d = (sfr_req && !sfr_we && sfr_grant) ? sfr_file_rdata : 8'h00;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= '0;
			program_status_high_reg_q <= '0;
			seg_ptr_q <= '0;
			firewall_ctrl_low_q <= '0;
			firewall_ctrl_high_q <= '0;
			exchange_window_base_low_q <= '0;
			exchange_window_base_high_q <= '0;
			exchange_window_size_low_q <= '0;
			exchange_window_size_high_q <= '0;
			seg_idx_q <= '0;
			seg_bnd_q <= '0;
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_paddr_q <= '0;
			mem_fault_q <= 1'b0;
			sfr_ack_q <= 1'b0;
			sfr_den_q <= 1'b0;
			sfr_we_q <= 1'b0;
			sfr_rd_q <= '0;
			mode_q <= MODE_USER;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			program_status_high_reg_q <= psw_d;
			seg_ptr_q <= seg_ptr_d;
			firewall_ctrl_low_q <= fwl_d;
			firewall_ctrl_high_q <= fwh_d;
			exchange_window_base_low_q <= xbl_d;
			exchange_window_base_high_q <= xbh_d;
			exchange_window_size_low_q <= xsl_d;
			exchange_window_size_high_q <= xsh_d;
			seg_idx_q <= seg_idx_d;
			seg_bnd_q <= seg_bnd_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			mem_req_q <= mem_req_d;
			mem_we_q <= mem_we_d;
			mem_paddr_q <= mem_paddr_d;
			mem_fault_q <= mem_fault_d;
			sfr_ack_q <= sfr_ack_d;
			sfr_den_q <= sfr_den_d;
			sfr_we_q <= sfr_we_d;
			sfr_rd_q <= sfr_rd_d;
			mode_q <= mode_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign mem_req = mem_req_q;
	assign mem_we = mem_we_q;
	assign mem_paddr = mem_paddr_q;
	assign mem_fault = mem_fault_q;
	assign sfr_ack = sfr_ack_q;
	assign sfr_denied = sfr_den_q;
	assign sfr_file_we = sfr_we_q;
	assign sfr_rdata = sfr_rd_q;
	assign cpu_mode = mode_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_denied_read_zero: assert property (sfr_den_q |-> sfr_rd_q == 8'h00)
		else $error("denied register read returned data");
	chk_denied_write_drop: assert property (sfr_req && !sfr_grant |=> !sfr_we_q)
		else $error("denied register write reached the file");
	chk_fault_no_access: assert property (cpu_req && !ok |=> mem_fault_q && !mem_req_q)
		else $error("refused access was forwarded");
	chk_user_needs_segment: assert property (cpu_req && mode_q == MODE_USER && !va_hit
		|=> !mem_req_q)
		else $error("user access without segment forwarded");
	chk_user_relocate: assert property (cpu_req && ok && mode_q == MODE_USER
		|=> mem_paddr_q == $past(PA_W'(cpu_vaddr) + va_offset))
		else $error("user physical address not relocated");
	chk_segptr_sys_only: assert property (wr_acc && paddr == A_SEG_PTR && !sys_ok
		|=> $stable(seg_ptr_q))
		else $error("segment pointer written outside System mode");
	chk_vector_suppressed: assert property (vector_call_instr && ctrl_q[CTRL_SUPPRESS_BIT]
		&& !wr_acc |=> $stable(program_status_high_reg_q))
		else $error("vector call changed mode while suppressed");
	chk_user_hw_gate: assert property (sfr_req && mode_q == MODE_USER && sfr_addr[7:5] == G_HW
		&& !sfr_we && !pc_rights[ATR_HR-ATR_R] |=> sfr_den_q)
		else $error("user hardware read granted without segment right");
	chk_mmu_group_sys: assert property (sfr_req && sfr_addr[7:5] == G_MMU
		&& mode_q != MODE_SYS |=> sfr_den_q)
		else $error("segmentation register reached outside System mode");
	chk_mode_follow: assert property (ctrl_q[1:0] == IB_BOOT ##1 ctrl_q[1:0] == IB_BOOT
		|-> mode_q == MODE_BOOT)
		else $error("mode does not follow internal boot bits");
	chk_apb_ready: assert property (psel && !penable |=> pready_q ##1 !pready_q)
		else $error("apb ready not a single cycle");
endmodule

/* File: tb/cpu_core_model.sv */
// CPU core model: issues memory and register requests, answers register file reads.
// Assumes one clock; each request is a one-cycle pulse driven after a rising edge.
`timescale 1ns/1ps
module cpu_core_model
	import mmu_access_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Memory request
	output logic cpu_req,
	output acc_type cpu_kind,
	output logic [VA_W-1:0] cpu_vaddr,
	output logic [VA_W-1:0] cpu_pc,
	output logic vector_call_instr,
	// Register request
	output logic sfr_req,
	output logic sfr_we,
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_file_rdata
);
	logic [7:0] idle_q = 8'h00;

	initial
	begin
		cpu_req = 1'b0;
		cpu_kind = ACC_READ;
		cpu_vaddr = 16'h0000;
		cpu_pc = 16'h0000;
		vector_call_instr = 1'b0;
		sfr_req = 1'b0;
		sfr_we = 1'b0;
		sfr_addr = 8'h00;
	end

	// Unselected file data keeps changing so a stale value is never mistaken
	always @(posedge pclk)
		idle_q <= idle_q + 8'h3B;
	assign sfr_file_rdata = sfr_req ? (sfr_addr ^ 8'h5A) : idle_q;

	task automatic mem_op(input acc_type k, input logic [15:0] va, input logic [15:0] pc);
		@(posedge pclk);
		cpu_req <= 1'b1;
		cpu_kind <= k;
		cpu_vaddr <= va;
		cpu_pc <= pc;
		@(posedge pclk);
		cpu_req <= 1'b0;
		cpu_vaddr <= ~va;
	endtask

	task automatic sfr_op(input logic w, input logic [7:0] a, input logic [15:0] pc);
		@(posedge pclk);
		sfr_req <= 1'b1;
		sfr_we <= w;
		sfr_addr <= a;
		cpu_pc <= pc;
		@(posedge pclk);
		sfr_req <= 1'b0;
		sfr_addr <= ~a;
	endtask

	task automatic vcall();
		@(posedge pclk);
		vector_call_instr <= 1'b1;
		@(posedge pclk);
		vector_call_instr <= 1'b0;
	endtask
endmodule

/* File: tb/mmu_sfr_access_control_test.sv */
// Self-checking bench of the memory and register access gate.
// Assumes the CPU core model drives the CPU ports and the bench is the APB master.
`timescale 1ns/1ps
module mmu_sfr_access_control_test
	import mmu_access_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, cpu_req, vector_call_instr, mem_req, mem_we, mem_fault;
	logic sfr_req, sfr_we, sfr_ack, sfr_denied, sfr_file_we;
	acc_type cpu_kind;
	logic [VA_W-1:0] cpu_vaddr, cpu_pc;
	logic [PA_W-1:0] mem_paddr;
	logic [7:0] sfr_addr, sfr_file_rdata, sfr_rdata;
	mode_type cpu_mode;
	int n_mismatch = 0;
	int checks = 0;
	logic [35:0] exp_q[$];
	logic [31:0] bnd[4] = '{32'h2FFF_2000, 32'h4FFF_4000, 32'h60FF_6000, 32'h30FF_3000};
	logic [31:0] atr[4] = '{32'h0012_0100, 32'h0007_0400, 32'h0000_0100, 32'h0028_4000};

	mmu_sfr_access_control mmu_sfr_access_control_i (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .cpu_req, .cpu_kind, .cpu_vaddr, .cpu_pc, .vector_call_instr, .mem_req,
		.mem_we, .mem_paddr, .mem_fault, .sfr_req, .sfr_we, .sfr_addr, .sfr_file_rdata,
		.sfr_ack, .sfr_denied, .sfr_file_we, .sfr_rdata, .cpu_mode
	);
	cpu_core_model cpu_core_model_i (
		.pclk, .cpu_req, .cpu_kind, .cpu_vaddr, .cpu_pc, .vector_call_instr, .sfr_req,
		.sfr_we, .sfr_addr, .sfr_file_rdata
	);

	initial
		forever #4 pclk = ~pclk;

	task automatic fail(input string m);
		n_mismatch++;
		$display("MISMATCH %0t %s", $time, m);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Expectation word: check-data flag, channel, then the channel's result fields
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [33:0] e);
		int n;
		exp_q.push_back({e[33], 2'h1, e[32], e[33] ? e[31:0] : 32'h0000_0000});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
		begin
			fail("no pready");
			complete_run();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, {2'b00, 32'h0000_0000});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d);
		apb(1'b0, a, 32'h0000_0000, {2'b10, d});
	endtask

	task automatic mem(input acc_type k, input logic [15:0] va, input logic f,
		input logic [16:0] pa);
		exp_q.push_back({3'b110, 13'h0000, f, !f, f ? 18'h0_0000 : {k == ACC_WRITE, pa}});
		cpu_core_model_i.mem_op(k, va, va);
	endtask

	task automatic sfr(input logic w, input logic [7:0] a, input logic [15:0] pc, input logic f);
		exp_q.push_back({3'b111, 23'h00_0000, f, w & !f, (f | w) ? 8'h00 : a ^ 8'h5A});
		cpu_core_model_i.sfr_op(w, a, pc);
	endtask

	task automatic mode_is(input mode_type m);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		checks++;
		if (cpu_mode !== m)
			fail("cpu mode");
	endtask

	// Takes the oldest expectation whenever any result shows
	always @(negedge pclk)
	begin
		logic [35:0] e;
		logic [34:0] g;
		g = 35'h0_0000_0000;
		if (pready === 1'b1)
			g = {2'h1, pslverr, prdata};
		else if (mem_req === 1'b1 || mem_fault === 1'b1)
			g = {2'h2, 13'h0000, mem_fault, mem_req, mem_fault ? 18'h0_0000 : {mem_we, mem_paddr}};
		else if (sfr_ack === 1'b1)
			g = {2'h3, 23'h00_0000, sfr_denied, sfr_file_we, sfr_rdata};
		if (g[34:33] != 2'h0)
		begin
			checks++;
			if (exp_q.size() == 0)
				fail("result with nothing expected");
			else
			begin
				e = exp_q.pop_front();
				if (!e[35])
					g[31:0] = 32'h0000_0000;
				if (g !== e[34:0])
					fail($sformatf("got %h want %h", g, e[34:0]));
			end
		end
	end

	initial
	begin
		logic [15:0] va;
		void'($urandom(32'hea0147e1));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		mode_is(MODE_USER);
		rd(A_STATUS, 32'h0000_0010);
		apb(1'b0, 8'h34, 32'h0000_0000, {2'b01, 32'h0000_0000});
		$display("test reset done");
		wr(A_PSW, 32'h0000_0080);
		mode_is(MODE_SYS);
		wr(A_SEG_PTR, 32'h0001_2340);
		rd(A_SEG_PTR, 32'h0001_2340);
		wr(A_FW_LO, 32'h0000_0001);
		wr(A_FW_HI, 32'h0000_0002);
		rd(A_FW_LO, 32'h0000_0001);
		wr(A_XS_LO, 32'h0000_0020);
		rd(A_XS_LO, 32'h0000_0020);
		for (int i = 0; i < 4; i++)
		begin
			wr(A_SEG_IDX, 32'(i));
			wr(A_SEG_BND, bnd[i]);
			wr(A_SEG_ATR, atr[i]);
		end
		mem(ACC_READ, 16'h1000, 1'b0, 17'h0_1000);
		mem(ACC_READ, 16'h0FFF, 1'b1, 17'h0_0000);
		mem(ACC_WRITE, 16'h1000, 1'b1, 17'h0_0000);
		mem(ACC_READ, 16'h8100, 1'b1, 17'h0_0000);
		mem(ACC_WRITE, 16'h8900, 1'b0, 17'h0_8900);
		$display("test system done");
		wr(A_PSW, 32'h0000_0000);
		mode_is(MODE_USER);
		mem(ACC_READ, 16'h2010, 1'b0, 17'h0_2110);
		mem(ACC_READ, 16'h2FFF, 1'b0, 17'h0_30FF);
		mem(ACC_WRITE, 16'h2010, 1'b1, 17'h0_0000);
		mem(ACC_WRITE, 16'h4008, 1'b0, 17'h1_4408);
		mem(ACC_EXEC, 16'h4008, 1'b1, 17'h0_0000);
		mem(ACC_READ, 16'h6000, 1'b1, 17'h0_0000);
		mem(ACC_READ, 16'h8000, 1'b1, 17'h0_0000);
		mem(ACC_EXEC, 16'h3010, 1'b0, 17'h0_7010);
		mem(ACC_READ, 16'h3000, 1'b1, 17'h0_0000);
		for (int i = 0; i < 8; i++)
		begin
			va = {4'h2, 12'($urandom)};
			mem(ACC_READ, va, 1'b0, {1'b0, va} + 17'h0_0100);
		end
		sfr(1'b0, 8'hC3, 16'h2000, 1'b0);
		sfr(1'b1, 8'hC3, 16'h2000, 1'b1);
		sfr(1'b0, 8'hC3, 16'h4000, 1'b1);
		sfr(1'b1, 8'hC3, 16'h3000, 1'b0);
		sfr(1'b0, 8'h20, 16'h2000, 1'b1);
		sfr(1'b1, 8'h05, 16'h4000, 1'b0);
		wr(A_SEG_PTR, 32'h0000_0000);
		rd(A_SEG_PTR, 32'h0001_2340);
		$display("test user done");
		wr(A_PSW, 32'h0000_0040);
		mode_is(MODE_COS);
		sfr(1'b0, 8'hC0, 16'h0000, 1'b0);
		sfr(1'b0, 8'hC1, 16'h0000, 1'b1);
		sfr(1'b1, 8'hC1, 16'h0000, 1'b0);
		sfr(1'b1, 8'hC0, 16'h0000, 1'b1);
		sfr(1'b1, 8'h85, 16'h0000, 1'b0);
		mem(ACC_READ, 16'h0800, 1'b0, 17'h0_0800);
		mem(ACC_READ, 16'h8100, 1'b0, 17'h0_8100);
		mem(ACC_READ, 16'h2000, 1'b1, 17'h0_0000);
		$display("test firewall done");
		wr(A_PSW, 32'h0000_0000);
		cpu_core_model_i.vcall();
		mode_is(MODE_COS);
		wr(A_PSW, 32'h0000_0000);
		wr(A_CTRL, 32'h0000_0004);
		cpu_core_model_i.vcall();
		mode_is(MODE_USER);
		rd(A_PSW, 32'h0000_0000);
		$display("test vector call done");
		wr(A_CTRL, 32'h0000_0008);
		wr(A_PSW, 32'h0000_0080);
		mode_is(MODE_SYS);
		mem(ACC_READ, 16'h8040, 1'b1, 17'h0_0000);
		mem(ACC_READ, 16'h8100, 1'b0, 17'h0_8100);
		$display("test no os done");
		wr(A_PSW, 32'h0000_0000);
		wr(A_CTRL, 32'h0000_0001);
		mode_is(MODE_BOOT);
		sfr(1'b0, 8'h20, 16'h0000, 1'b1);
		sfr(1'b0, 8'hC3, 16'h0000, 1'b0);
		wr(A_CTRL, 32'h0000_0002);
		mode_is(MODE_TEST);
		mem(ACC_READ, 16'h0800, 1'b0, 17'h0_0800);
		$display("test boot and test modes done");
		repeat (4) @(posedge pclk);
		if (exp_q.size() != 0)
			fail("results missing");
		complete_run();
	end
endmodule
